// [design/gms_pkg.sv]
package gms_pkg;

	// Clock and refresh timing
	localparam int          CLK_FREQ_MHZ      = 40;
	localparam int          REFRESH_PERIOD_US = 10000;
	localparam int          REFRESH_CYCLES    = REFRESH_PERIOD_US * CLK_FREQ_MHZ;

	// Connection parameters
	localparam logic [15:0] TCP_PORT          = 16'h01f6;
	localparam logic [7:0]  TCP_UNIT_ID       = 8'h02;
	localparam logic [7:0]  RTU_SLAVE_ID      = 8'h09;
	localparam logic [15:0] PROTO_ID          = 16'h0000;

	// Function and exception codes
	localparam logic [7:0]  FC_READ_HOLD      = 8'h03;
	localparam logic [7:0]  FC_READ_INPUT     = 8'h04;
	localparam logic [7:0]  FC_WRITE_MULTI    = 8'h10;
	localparam logic [7:0]  EXC_FLAG          = 8'h80;
	localparam logic [7:0]  EXC_ILLEGAL_FUNC  = 8'h01;
	localparam logic [7:0]  EXC_ILLEGAL_ADDR  = 8'h02;

	// Status word addresses on the serial framing
	localparam logic [15:0] REG_GRIPPER_AND_OBJECT_STATE      = 16'h07d0;
	localparam logic [15:0] REG_FAULT_AND_REQUEST_ECHO        = 16'h07d1;
	localparam logic [15:0] REG_FIRST_FINGER_POSITION_CURRENT = 16'h07d2;
	localparam logic [15:0] REG_SECOND_FINGER_ECHO_POSITION   = 16'h07d3;
	localparam logic [15:0] REG_SECOND_CURRENT_THIRD_ECHO     = 16'h07d4;
	localparam logic [15:0] REG_THIRD_FINGER_POSITION_CURRENT = 16'h07d5;
	localparam logic [15:0] REG_SPREAD_AXIS_ECHO_POSITION     = 16'h07d6;
	localparam logic [15:0] REG_SPREAD_AXIS_CURRENT           = 16'h07d7;

	// Block bases
	localparam logic [15:0] TCP_STATUS_BASE   = 16'h0000;
	localparam logic [15:0] TCP_COMMAND_BASE  = 16'h0000;
	localparam logic [15:0] RTU_COMMAND_BASE  = 16'h03e8;
	localparam logic [15:0] BANK_WORDS        = 16'h0008;

	// Frame layout
	localparam logic [3:0]  TCP_MBAP_BYTES    = 4'h6;
	localparam logic [3:0]  PDU_DATA_POS      = 4'h7;
	localparam logic [7:0]  RTU_CRC_BYTES     = 8'h02;
	localparam int          HDR_BYTES         = 13;

	// Motion state field position and codes
	localparam int          MOTION_MSB        = 7;
	localparam int          MOTION_LSB        = 6;
	localparam logic [1:0]  MOTION_MOVING     = 2'h0;
	localparam logic [1:0]  MOTION_SOME_SHORT = 2'h1;
	localparam logic [1:0]  MOTION_ALL_SHORT  = 2'h2;
	localparam logic [1:0]  MOTION_REACHED    = 2'h3;

	// Check sum
	localparam logic [15:0] CRC_INIT          = 16'hffff;
	localparam logic [15:0] CRC_POLY          = 16'ha001;

	// One axis as the motor core reports it
	typedef struct packed {
		logic [7:0] echo;
		logic [7:0] pos;
		logic [7:0] cur;
	} gms_axis_type;

	// Live status from the motor core; axis 0..2 fingers, 3 spread axis
	typedef struct packed {
		logic [5:0]             misc;
		logic [7:0]             object;
		logic [7:0]             fault;
		logic [7:0]             req_echo;
		logic [3:0]             stopped;
		logic [3:0]             at_target;
		gms_axis_type [3:0]     axis;
	} gms_core_type;

	// Byte stream beat
	typedef struct packed {
		logic       valid;
		logic       last;
		logic [7:0] data;
	} gms_stream_type;

	typedef logic [15:0][7:0] gms_bank_type;

	typedef enum logic [1:0] {GMS_RESP_READ, GMS_RESP_WRITE, GMS_RESP_EXC} gms_resp_type;

	typedef enum logic [1:0] {GMS_IDLE, GMS_DECODE, GMS_SEND} gms_state_type;

	// Reflected CRC-16 step over one byte
	function automatic logic [15:0] gms_crc_step(input logic [15:0] crc, input logic [7:0] b);
		logic [15:0] c;
		c = crc ^ {8'h00, b};
		for (int i = 0; i < 8; i++) begin
			c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
		end
		return c;
	endfunction

endpackage

// [design/gms_refresh.sv]
`timescale 1ns/1ps
module gms_refresh import gms_pkg::*; #(
	parameter int unsigned REFRESH_CYCLES_P = REFRESH_CYCLES
) (
	input  wire logic         i_ref_clk,
	input  wire logic         i_nrst,
	input  wire gms_bank_type i_bank,
	output gms_bank_type      o_bank
);

	localparam int CW = $clog2(REFRESH_CYCLES_P + 1);

	logic [CW-1:0] cnt_q;   // Cycles since the last snapshot
	gms_bank_type  bank_q;  // Bank as the master sees it
	wire           tick;    // Snapshot instant

	assign tick   = (cnt_q == CW'(REFRESH_CYCLES_P - 1));
	assign o_bank = bank_q;

	// Free-running refresh timer; master polls faster than this see repeats
	always_ff @(posedge i_ref_clk) begin
		if (!i_nrst) begin
			cnt_q <= '0;
		end else begin
			cnt_q <= tick ? '0 : cnt_q + 1'b1;
		end
	end

	// Snapshot changes only at a tick, so a reply stays coherent unless a tick falls while it is being sent
	always_ff @(posedge i_ref_clk) begin
		if (!i_nrst) begin
			bank_q <= '0;
		end else if (tick) begin
			bank_q <= i_bank;
		end
	end

endmodule

// [design/gms_modbus_server.sv]
// Summary of operation
// - Read reply: id, function, count, words, checksum on serial
// - Word one: gripper status high, object low
// - Motion field zero while fingers still move
// - Motion field three when all reached target
// - Word two: fault high, request echo low
// - Word three: finger A position, current
// - Words four to six pack fingers B, C
// - Words seven, eight hold spread axis data
// - Contents refresh at 100 Hz; master spaces
// - TCP accepts only functions four and sixteen
// - TCP command and status blocks start zero
// - Each word joins two consecutive gripper bytes
// - Function four returns the status words on TCP; serial reads them with function three
// - Multiple write updates commands, echoes header back
`timescale 1ns/1ps
module gms_modbus_server import gms_pkg::*; #(
	parameter int unsigned REFRESH_CYCLES_P = REFRESH_CYCLES
) (
	input  wire logic           i_ref_clk,
	input  wire logic           i_nrst,
	input  wire logic           i_rtu_mode,
	input  wire logic [15:0]    i_conn_port,
	input  wire gms_core_type   i_core,
	input  wire gms_stream_type i_rx,
	output logic                o_rx_ready,
	output gms_stream_type      o_tx,
	input  wire logic           i_tx_ready,
	output gms_bank_type        o_cmd_bytes,
	output logic                o_cmd_strobe
);

	gms_state_type              state_q;     // Frame sequencer
	gms_resp_type               resp_q;      // Kind of reply being sent
	logic [7:0]                 exc_q;       // Exception code of a refused request
	logic [7:0]                 rx_idx_q;    // Bytes taken in this frame
	logic [7:0]                 tx_idx_q;    // Bytes sent of the reply
	logic [HDR_BYTES-1:0][7:0]  hdr_q;       // Captured frame head
	gms_bank_type               pend_q;      // Write data held until the frame checks out
	gms_bank_type               cmd_q;       // Command bytes in force
	logic [15:0]                crc_q;       // Running check sum, shared by rx and tx
	logic                       ready_q;     // Accepting request bytes
	logic                       strobe_q;    // Command bank just updated
	gms_stream_type             tx_q;        // Reply byte register

	gms_bank_type               live_bank;   // Status packed from the core
	gms_bank_type               snap_bank;   // Status as last refreshed
	wire  [1:0]                 motion;      // Motion state field value

	// Motion state: moving until every axis stops, then reached or short
	assign motion = !(&i_core.stopped) ? MOTION_MOVING :
		(&i_core.at_target) ? MOTION_REACHED :
		(|i_core.at_target) ? MOTION_SOME_SHORT : MOTION_ALL_SHORT;

	// Byte map of the status bank; word n is bytes 2n and 2n+1
	assign live_bank[0]  = {motion, i_core.misc};
	assign live_bank[1]  = i_core.object;
	assign live_bank[2]  = i_core.fault;
	assign live_bank[3]  = i_core.req_echo;
	assign live_bank[4]  = i_core.axis[0].pos;
	assign live_bank[5]  = i_core.axis[0].cur;
	assign live_bank[6]  = i_core.axis[1].echo;
	assign live_bank[7]  = i_core.axis[1].pos;
	assign live_bank[8]  = i_core.axis[1].cur;
	assign live_bank[9]  = i_core.axis[2].echo;
	assign live_bank[10] = i_core.axis[2].pos;
	assign live_bank[11] = i_core.axis[2].cur;
	assign live_bank[12] = i_core.axis[3].echo;
	assign live_bank[13] = i_core.axis[3].pos;
	assign live_bank[14] = i_core.axis[3].cur;
	assign live_bank[15] = 8'h00;                       // Low half of last word is unused

	// Periodic snapshot of the bank
	gms_refresh #(
		.REFRESH_CYCLES_P (REFRESH_CYCLES_P)
	) u_refresh (
		.i_ref_clk (i_ref_clk),
		.i_nrst    (i_nrst),
		.i_bank    (live_bank),
		.o_bank    (snap_bank)
	);

	// Framing: the mode pin is a static strap, not changed mid-frame
	wire        rtu     = i_rtu_mode;
	wire  [3:0] hoff    = rtu ? 4'h0 : TCP_MBAP_BYTES;   // Where the unit byte sits
	wire  [7:0] dstart  = {4'h0, hoff + PDU_DATA_POS};   // First write data byte
	wire        rx_take = i_rx.valid && ready_q;
	wire  [7:0] rx_didx = rx_idx_q - dstart;

	// Request fields, offset by the MBAP header on TCP
	wire  [15:0] f_tid  = {hdr_q[0], hdr_q[1]};
	wire  [15:0] f_pid  = {hdr_q[2], hdr_q[3]};
	wire  [7:0]  f_unit = hdr_q[hoff];
	wire  [7:0]  f_fc   = hdr_q[hoff + 4'h1];
	wire  [15:0] f_addr = {hdr_q[hoff + 4'h2], hdr_q[hoff + 4'h3]};
	wire  [15:0] f_cnt  = {hdr_q[hoff + 4'h4], hdr_q[hoff + 4'h5]};
	wire  [7:0]  f_bc   = hdr_q[hoff + 4'h6];

	// Who is addressed; a bad check sum on serial framing is dropped silently
	wire        long_ok = rx_idx_q >= {4'h0, hoff + 4'h6};
	wire        rtu_hit = (f_unit == RTU_SLAVE_ID) && (crc_q == 16'h0000);
	wire        tcp_hit = (f_pid == PROTO_ID) && (i_conn_port == TCP_PORT)
		&& (f_unit == TCP_UNIT_ID);
	wire        hit     = long_ok && (rtu ? rtu_hit : tcp_hit);

	// Function and range checks
	wire [7:0]  fc_rd   = rtu ? FC_READ_HOLD : FC_READ_INPUT;
	wire        is_rd   = (f_fc == fc_rd);
	wire        is_wr   = (f_fc == FC_WRITE_MULTI);
	wire [15:0] rd_base = rtu ? REG_GRIPPER_AND_OBJECT_STATE : TCP_STATUS_BASE;
	wire [15:0] wr_base = rtu ? RTU_COMMAND_BASE : TCP_COMMAND_BASE;
	wire [15:0] rd_rel  = f_addr - rd_base;
	wire [15:0] wr_rel  = f_addr - wr_base;
	wire        cnt_ok  = (f_cnt != 16'h0000) && (f_cnt <= BANK_WORDS);
	wire [16:0] rd_end  = {1'b0, rd_rel} + {1'b0, f_cnt};
	wire [16:0] wr_end  = {1'b0, wr_rel} + {1'b0, f_cnt};
	wire        rd_ok   = cnt_ok && (f_addr >= rd_base) && (rd_end <= {1'b0, BANK_WORDS});
	// Only the command bank is writable; on serial framing status addresses refuse with an exception
	wire        wr_ok   = cnt_ok && (f_addr >= wr_base) && (wr_end <= {1'b0, BANK_WORDS})
		&& (f_bc == {f_cnt[6:0], 1'b0}) && (rx_idx_q >= dstart + f_bc);
	wire        do_wr   = (state_q == GMS_DECODE) && hit && is_wr && wr_ok;

	// Reply sizing
	wire [7:0]  body_n  = (resp_q == GMS_RESP_READ) ? 8'h03 + {f_cnt[6:0], 1'b0} :
		(resp_q == GMS_RESP_WRITE) ? 8'h06 : 8'h03;
	wire [7:0]  tx_tot  = body_n + (rtu ? RTU_CRC_BYTES : {4'h0, TCP_MBAP_BYTES});
	wire [7:0]  p       = tx_idx_q - {4'h0, hoff};
	wire [7:0]  p_data  = p - 8'h03;
	wire [3:0]  rd_idx  = {rd_rel[2:0], 1'b0} + p_data[3:0];
	wire        tx_adv  = !tx_q.valid || i_tx_ready;
	wire        tx_more = tx_idx_q < tx_tot;
	wire        in_body = rtu ? (p < body_n) : 1'b1;
	logic [7:0] tx_byte;                                      // Next reply byte

	// Reply byte selection by position
	always_comb begin
		tx_byte = 8'h00;
		if (!rtu && (tx_idx_q < {4'h0, TCP_MBAP_BYTES})) begin
			unique case (tx_idx_q[2:0])
				3'h0:    tx_byte = f_tid[15:8];          // Transaction id echoed
				3'h1:    tx_byte = f_tid[7:0];
				3'h2:    tx_byte = f_pid[15:8];
				3'h3:    tx_byte = f_pid[7:0];
				3'h4:    tx_byte = 8'h00;                // Length never exceeds 255
				default: tx_byte = body_n;               // Length counts unit onward
			endcase
		end else if (!in_body) begin
			tx_byte = (p == body_n) ? crc_q[7:0] : crc_q[15:8];  // Low byte first
		end else begin
			unique case (p)
				8'h00: tx_byte = f_unit;
				8'h01: tx_byte = (resp_q == GMS_RESP_EXC) ? (f_fc | EXC_FLAG) : f_fc;
				8'h02: begin
					if (resp_q == GMS_RESP_READ) begin
						tx_byte = {f_cnt[6:0], 1'b0};    // Twice the word count
					end else if (resp_q == GMS_RESP_EXC) begin
						tx_byte = exc_q;
					end else begin
						tx_byte = f_addr[15:8];
					end
				end
				8'h03: tx_byte = (resp_q == GMS_RESP_WRITE) ? f_addr[7:0] : snap_bank[rd_idx];
				8'h04: tx_byte = (resp_q == GMS_RESP_WRITE) ? f_cnt[15:8] : snap_bank[rd_idx];
				8'h05: tx_byte = (resp_q == GMS_RESP_WRITE) ? f_cnt[7:0] : snap_bank[rd_idx];
				default: tx_byte = snap_bank[rd_idx];    // High byte of each word first
			endcase
		end
	end

	// Frame sequencer: take request, judge it, send reply
	always_ff @(posedge i_ref_clk) begin
		if (!i_nrst) begin
			state_q <= GMS_IDLE;
			resp_q  <= GMS_RESP_EXC;
			exc_q   <= 8'h00;
			ready_q <= 1'b0;
		end else begin
			unique case (state_q)
				GMS_IDLE: begin
					ready_q <= !(rx_take && i_rx.last);
					if (rx_take && i_rx.last) begin
						state_q <= GMS_DECODE;
					end
				end
				GMS_DECODE: begin
					if (!hit) begin
						state_q <= GMS_IDLE;         // Not for us: no reply at all
						ready_q <= 1'b1;
					end else if (is_rd && rd_ok) begin
						state_q <= GMS_SEND;
						resp_q  <= GMS_RESP_READ;
					end else if (is_wr && wr_ok) begin
						state_q <= GMS_SEND;
						resp_q  <= GMS_RESP_WRITE;
					end else begin
						state_q <= GMS_SEND;
						resp_q  <= GMS_RESP_EXC;
						exc_q   <= (is_rd || is_wr) ? EXC_ILLEGAL_ADDR : EXC_ILLEGAL_FUNC;
					end
				end
				GMS_SEND: begin
					if (tx_adv && !tx_more) begin
						state_q <= GMS_IDLE;
						ready_q <= 1'b1;
					end
				end
			endcase
		end
	end

	// Byte counters
	always_ff @(posedge i_ref_clk) begin
		if (!i_nrst) begin
			rx_idx_q <= 8'h00;
			tx_idx_q <= 8'h00;
		end else if (state_q == GMS_IDLE) begin
			tx_idx_q <= 8'h00;
			if (rx_take && (rx_idx_q != 8'hff)) begin
				rx_idx_q <= rx_idx_q + 8'h01;     // Saturates on runaway frames
			end
		end else if (state_q == GMS_SEND) begin
			if (tx_adv && tx_more) begin
				tx_idx_q <= tx_idx_q + 8'h01;
			end else if (tx_adv) begin
				rx_idx_q <= 8'h00;                // Head stays intact until reply ends
			end
		end else if (!hit) begin
			rx_idx_q <= 8'h00;
		end
	end

	// Head capture and write data staging
	always_ff @(posedge i_ref_clk) begin
		if (!i_nrst) begin
			hdr_q  <= '0;
			pend_q <= '0;
		end else if (rx_take) begin
			if (rx_idx_q < 8'(HDR_BYTES)) begin
				hdr_q[rx_idx_q[3:0]] <= i_rx.data;
			end
			if ((rx_idx_q >= dstart) && (rx_didx < 8'h10)) begin
				pend_q[rx_didx[3:0]] <= i_rx.data;
			end
		end
	end

	// Check sum: over request bytes, then restarted for the reply
	always_ff @(posedge i_ref_clk) begin
		if (!i_nrst) begin
			crc_q <= CRC_INIT;
		end else if (rx_take) begin
			crc_q <= gms_crc_step(crc_q, i_rx.data);   // Residue zero on a good frame
		end else if (state_q == GMS_DECODE) begin
			crc_q <= CRC_INIT;
		end else if ((state_q == GMS_SEND) && tx_adv && tx_more && in_body) begin
			crc_q <= gms_crc_step(crc_q, tx_byte);
		end else if ((state_q == GMS_SEND) && tx_adv && !tx_more) begin
			crc_q <= CRC_INIT;
		end
	end

	// Reply output register; holds a byte until the sink takes it
	always_ff @(posedge i_ref_clk) begin
		if (!i_nrst) begin
			tx_q <= '0;
		end else if ((state_q == GMS_SEND) && tx_adv) begin
			tx_q.valid <= tx_more;
			tx_q.last  <= tx_more && (tx_idx_q == tx_tot - 8'h01);
			tx_q.data  <= tx_more ? tx_byte : 8'h00;
		end else if (tx_adv) begin
			tx_q <= '0;
		end
	end

	// Command bank update; a whole write lands at once or not at all
	for (genvar k = 0; k < 16; k++) begin : g_cmd
		wire [4:0] lo  = {1'b0, wr_rel[2:0], 1'b0};
		wire [4:0] hi  = lo + {f_cnt[3:0], 1'b0};
		wire       sel = (5'(k) >= lo) && (5'(k) < hi);
		wire [3:0] src = 4'(k) - lo[3:0];
		always_ff @(posedge i_ref_clk) begin
			if (!i_nrst) begin
				cmd_q[k] <= 8'h00;
			end else if (do_wr && sel) begin
				cmd_q[k] <= pend_q[src];
			end
		end
	end

	// One-cycle notice to the motor core that commands changed
	always_ff @(posedge i_ref_clk) begin
		if (!i_nrst) begin
			strobe_q <= 1'b0;
		end else begin
			strobe_q <= do_wr;
		end
	end

	assign o_rx_ready   = ready_q;
	assign o_tx         = tx_q;
	assign o_cmd_bytes  = cmd_q;
	assign o_cmd_strobe = strobe_q;

endmodule

// [tb/gms_modbus_server_assertions.sv]
`timescale 1ns/1ps
module gms_modbus_server_assertions import gms_pkg::*; #(
	parameter int unsigned REFRESH_CYCLES_P = REFRESH_CYCLES
) (
	input wire logic           i_ref_clk,
	input wire logic           i_nrst,
	input wire logic           i_rtu_mode,
	input wire logic [15:0]    i_conn_port,
	input wire gms_core_type   i_core,
	input wire gms_stream_type i_rx,
	input wire logic           o_rx_ready,
	input wire gms_stream_type o_tx,
	input wire logic           i_tx_ready,
	input wire gms_bank_type   o_cmd_bytes,
	input wire logic           o_cmd_strobe
);
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (!i_nrst);

	// Final request byte handed over this edge
	wire take_last = i_rx.valid && i_rx.last && o_rx_ready;
	// Final reply byte handed over this edge
	wire give_last = o_tx.valid && o_tx.last && i_tx_ready;

	tx_hold_a: assert property (o_tx.valid && !i_tx_ready |=> o_tx.valid && $stable(o_tx))
		else $error("reply byte changed while stalled");
	reply_quiet_a: assert property (o_tx.valid |-> !o_rx_ready)
		else $error("request taken during a reply");
	frame_close_a: assert property (take_last |=> !o_rx_ready)
		else $error("request still taken after frame end");
	answer_due_a: assert property (take_last |=> ##[1:3] (o_tx.valid || o_rx_ready))
		else $error("no reply and no drop after frame");
	ready_back_a: assert property (give_last |=> ##[0:1] o_rx_ready)
		else $error("request side not reopened after reply");
	ready_fall_a: assert property ($past(i_nrst) && $fell(o_rx_ready) |-> $past(take_last))
		else $error("request side closed without frame end");
	strobe_single_a: assert property (o_cmd_strobe |=> !o_cmd_strobe)
		else $error("command strobe longer than one cycle");
	cmd_hold_a: assert property ($past(i_nrst) && !o_cmd_strobe |-> $stable(o_cmd_bytes))
		else $error("command bytes moved without strobe");

	// Main scenarios reached
	cover property (o_cmd_strobe);
	cover property (o_tx.valid && !i_tx_ready);
	cover property (give_last);
endmodule

bind gms_modbus_server gms_modbus_server_assertions #(.REFRESH_CYCLES_P(REFRESH_CYCLES_P)) u_chk (
	.i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .i_rtu_mode(i_rtu_mode),
	.i_conn_port(i_conn_port), .i_core(i_core), .i_rx(i_rx), .o_rx_ready(o_rx_ready),
	.o_tx(o_tx), .i_tx_ready(i_tx_ready), .o_cmd_bytes(o_cmd_bytes),
	.o_cmd_strobe(o_cmd_strobe));

// [tb/gms_master_model.sv]
`timescale 1ns/1ps
module gms_master_model import gms_pkg::*; (
	input  wire logic           i_ref_clk,
	input  wire logic           i_slow,
	input  wire logic           i_rx_ready,
	input  wire gms_stream_type i_tx,
	output gms_stream_type      o_rx,
	output logic                o_tx_ready
);
	logic [7:0] reply_q[$];  // Reply bytes as taken
	logic       reply_end;   // Final reply byte seen
	logic [1:0] pace;        // Stall pattern counter

	initial begin
		o_rx = '0;
		o_tx_ready = 1'b1;
		pace = 2'h0;
		reply_end = 1'b0;
	end

	// Slow sink takes one byte in four, so the hold path is exercised
	always @(negedge i_ref_clk) begin
		pace <= pace + 2'h1;
		o_tx_ready <= !i_slow || (pace == 2'h0);
	end

	// Capture at the edge where a byte is handed over
	always @(posedge i_ref_clk) begin
		if (i_tx.valid && o_tx_ready) begin
			reply_q.push_back(i_tx.data);
			reply_end <= i_tx.last;
		end
	end

	// Bytes go out in field order, each held until taken
	task automatic send(input logic [7:0] f[$]);
		for (int i = 0; i < f.size(); i++) begin
			o_rx <= '{1'b1, i == f.size() - 1, f[i]};
			// Ready is a flop: its level between edges says whether the next edge takes
			while (!i_rx_ready) @(negedge i_ref_clk);
			@(posedge i_ref_clk);
			@(negedge i_ref_clk);
		end
		// Released line must not keep showing the last byte
		o_rx <= '{1'b0, 1'b0, ~o_rx.data};
	endtask
endmodule

// [tb/gms_modbus_server_test.sv]
`timescale 1ns/1ps
module gms_modbus_server_test import gms_pkg::*; ();
	localparam int RC = 16;  // Short refresh keeps the run brief
	logic           clk;         // 40 MHz reference
	logic           nrst;        // Synchronous reset, low active
	logic           rtu;         // Serial framing select
	logic [15:0]    port;        // Connection port of the frame
	gms_core_type   core;        // Live motor core status
	gms_stream_type rx;          // Request bytes
	gms_stream_type tx;          // Reply bytes
	logic           rx_ready;
	logic           tx_ready;
	logic           slow;        // Sink stalls when set
	gms_bank_type   cmd;         // Command bytes
	logic           strobe;
	logic [159:0]   r;           // Random pool
	logic [7:0]     d[16];       // Written data
	logic [7:0]     req[$];      // Frame to send
	logic [7:0]     want[$];     // Reply expected
	int             strobes;
	int             num_errors;
	int             compares;
	int             seed;
	int             a;
	int             n;

	gms_modbus_server #(.REFRESH_CYCLES_P(RC)) u_gms_modbus_server (
		.i_ref_clk(clk), .i_nrst(nrst), .i_rtu_mode(rtu), .i_conn_port(port),
		.i_core(core), .i_rx(rx), .o_rx_ready(rx_ready), .o_tx(tx),
		.i_tx_ready(tx_ready), .o_cmd_bytes(cmd), .o_cmd_strobe(strobe));
	gms_master_model u_gms_master_model (
		.i_ref_clk(clk), .i_slow(slow), .i_rx_ready(rx_ready), .i_tx(tx),
		.o_rx(rx), .o_tx_ready(tx_ready));

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	// Command update pulses
	always @(posedge clk) begin
		if (strobe === 1'b1) strobes++;
	end

	task automatic check(input logic [7:0] seen, input logic [7:0] exp_v);
		compares++;
		if (seen !== exp_v) begin
			num_errors++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp_v);
		end
	endtask

	task automatic complete_run();
		if (num_errors == 0 && compares > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	// Status byte n as the bank should hold it
	function automatic logic [7:0] bank_byte(input gms_core_type c, input int n);
		logic [1:0] m;
		m = !(&c.stopped) ? MOTION_MOVING : (&c.at_target) ? MOTION_REACHED :
			(|c.at_target) ? MOTION_SOME_SHORT : MOTION_ALL_SHORT;
		case (n)
			0: return {m, c.misc};
			1: return c.object;
			2: return c.fault;
			3: return c.req_echo;
			4: return c.axis[0].pos;
			5: return c.axis[0].cur;
			6: return c.axis[1].echo;
			7: return c.axis[1].pos;
			8: return c.axis[1].cur;
			9: return c.axis[2].echo;
			10: return c.axis[2].pos;
			11: return c.axis[2].cur;
			12: return c.axis[3].echo;
			13: return c.axis[3].pos;
			14: return c.axis[3].cur;
			default: return 8'h00;
		endcase
	endfunction

	// Serial check sum, low byte first
	task automatic add_crc(ref logic [7:0] f[$]);
		logic [15:0] c;
		c = 16'hffff;
		foreach (f[i]) begin
			c ^= {8'h00, f[i]};
			for (int k = 0; k < 8; k++) c = c[0] ? (c >> 1) ^ 16'ha001 : c >> 1;
		end
		f.push_back(c[7:0]);
		f.push_back(c[15:8]);
	endtask

	// TCP header up to the function byte
	task automatic head(input logic [15:0] t, input logic [7:0] u, input logic [7:0] fc);
		req = '{t[15:8], t[7:0], 8'h00, 8'h00, 8'h00, 8'h06, u, fc};
		want = '{t[15:8], t[7:0], 8'h00, 8'h00};
	endtask

	// One exchange; an empty expectation means no reply
	task automatic xfer();
		u_gms_master_model.reply_q.delete();
		u_gms_master_model.reply_end = 1'b0;
		u_gms_master_model.send(req);
		for (int t = 0; t < 400 && !u_gms_master_model.reply_end; t++) @(negedge clk);
		check(8'(u_gms_master_model.reply_q.size()), 8'(want.size()));
		foreach (want[i]) check(u_gms_master_model.reply_q[i], want[i]);
		repeat (RC) @(negedge clk);
	endtask

	initial begin
		seed = 24919;
		nrst = 1'b0;
		rtu = 1'b0;
		port = TCP_PORT;
		core = '0;
		slow = 1'b0;
		repeat (16) @(negedge clk);
		nrst = 1'b1;
		repeat (2) @(negedge clk);
		// Random status reads; every motion case, both range ends
		for (int k = 0; k < 8; k++) begin
			r = {$random(seed), $random(seed), $random(seed), $random(seed), $random(seed)};
			core = r[$bits(core)-1:0];
			core.stopped = (k % 4 == 0) ? 4'hb : 4'hf;
			core.at_target = (k % 4 == 1) ? 4'hf : (k % 4 == 2) ? 4'h4 : 4'h0;
			a = (k == 0) ? 0 : (k == 1) ? 7 : {$random(seed)} % 8;
			n = (k == 0) ? 8 : 1 + {$random(seed)} % (8 - a);
			slow = k[0];
			repeat (3 * RC) @(negedge clk);
			head(16'(k * 257 + 3), 8'h02, FC_READ_INPUT);
			req = {req, 8'h00, 8'(a), 8'h00, 8'(n)};
			want = {want, 8'h00, 8'(3 + 2 * n), 8'h02, FC_READ_INPUT, 8'(2 * n)};
			for (int i = 0; i < 2 * n; i++) want.push_back(bank_byte(core, 2 * a + i));
			xfer();
		end
		// Serial full bank read, then a refused write to status words
		rtu = 1'b1;
		req = '{RTU_SLAVE_ID, FC_READ_HOLD, 8'h07, 8'hd0, 8'h00, 8'h08};
		add_crc(req);
		want = '{RTU_SLAVE_ID, FC_READ_HOLD, 8'h10};
		for (int i = 0; i < 16; i++) want.push_back(bank_byte(core, i));
		add_crc(want);
		xfer();
		req = '{RTU_SLAVE_ID, FC_WRITE_MULTI, 8'h07, 8'hd0, 8'h00, 8'h01, 8'h02, 8'h5a, 8'ha5};
		add_crc(req);
		want = '{RTU_SLAVE_ID, FC_WRITE_MULTI | EXC_FLAG, EXC_ILLEGAL_ADDR};
		add_crc(want);
		xfer();
		check({7'h00, |cmd}, 8'h00);
		// Command writes at the low end and the top end of the block
		rtu = 1'b0;
		for (int w = 0; w < 2; w++) begin
			a = 5 * w;
			n = 3;
			head(16'h0100 + 16'(w), 8'h02, FC_WRITE_MULTI);
			req = {req, 8'h00, 8'(a), 8'h00, 8'(n), 8'(2 * n)};
			for (int i = 0; i < 2 * n; i++) begin
				d[i] = 8'($random(seed));
				req.push_back(d[i]);
			end
			want = {want, 8'h00, 8'h06, 8'h02, FC_WRITE_MULTI, 8'h00, 8'(a), 8'h00, 8'(n)};
			xfer();
			for (int i = 0; i < 2 * n; i++) check(cmd[2 * a + i], d[i]);
		end
		// Unsupported functions and an oversize count refused; foreign unit or port ignored
		for (int f = 0; f < 5; f++) begin
			port = (f == 3) ? TCP_PORT + 16'h0001 : TCP_PORT;
			head(16'h2200, (f == 2) ? 8'h01 : 8'h02,
				(f == 0) ? FC_READ_HOLD : (f == 1) ? 8'h06 : FC_READ_INPUT);
			req = {req, 8'h00, 8'h00, 8'h00, (f == 4) ? 8'h09 : 8'h01};
			want = {want, 8'h00, 8'h03, 8'h02, req[7] | EXC_FLAG,
				(f == 4) ? EXC_ILLEGAL_ADDR : EXC_ILLEGAL_FUNC};
			if (f == 2 || f == 3) want.delete();
			xfer();
		end
		check(8'(strobes), 8'h02);
		complete_run();
	end

	// Watchdog well past the expected run length
	initial begin
		repeat (20000) @(posedge clk);
		num_errors++;
		complete_run();
	end
endmodule
